// ---- hw/temp_status_defs.vh ----
// register map, field positions and reset values of the result and status registers
// assumes the includer works on an 8-bit register read port
`ifndef TEMP_STATUS_DEFS_VH
`define TEMP_STATUS_DEFS_VH

`define ADDR_REMOTE_HIGH   8'h01
`define ADDR_ALARM_STATUS  8'h02
`define ADDR_REMOTE_LOW    8'h10
`define RESULT_HI_MSB      11
`define RESULT_HI_LSB      4
`define RESULT_LO_MSB      3
`define RESULT_LO_LSB      0
`define LOW_BYTE_PAD       4'h0
`define RESET_RD_DATA      8'h00
`define RESET_BUSY         1'b0
`define RESET_REMOTE_HIGH  8'h00
`define RESET_REMOTE_LOW   4'h0
`define RESET_FLAGS        7'h00
`define BIT_BUSY           7
`define BIT_OPEN_JUNCTION  2
`define FLAG_COUNT         7

`endif

// ---- hw/sticky_flag.v ----
// one sticky status flag: set by a cause, cleared by a status read if cause gone
// assumes cause and read strobe are synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module sticky_flag (
  input  wire clk,
  input  wire rst_n,
  input  wire set_evt,
  input  wire cause_now,
  input  wire latch_en,
  input  wire clr_rd,
  output wire flag
);
  reg flag_r;
  reg flag_nxt;

  always @* begin
    flag_nxt = flag_r;
    if (clr_rd && !cause_now)
      flag_nxt = 1'b0;
    if (!latch_en)
      flag_nxt = cause_now;
    if (set_evt)
      flag_nxt = 1'b1; // set wins over clear
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      flag_r <= 1'b0;
    else
      flag_r <= flag_nxt;
  end

  assign flag = flag_r;
endmodule // sticky_flag
`default_nettype wire

// ---- hw/temp_result_status_regs.v ----
// remote result high byte with byte-coherence lock, and the alarm status register
// assumes conversion engine, comparators and serial slave share CLK
//
// Overview of operation
// - high byte holds remote result bits 11:4
// - high byte loads at each conversion end unless locked; unwritable
// - high read first locks low byte updates
// - low read first locks high byte updates
// - lock ends on read of another register
// - status bit 7 shows converter busy
// - bit 6 sets on local over limit
// - bit 5 sets on local under limit
// - bit 4 sets on remote over limit
// - bit 3 sets on remote under limit
// - bit 2 sets on open remote junction
// - bit 1 sets on remote critical trip
// - bit 0 sets on local critical trip
// - status read clears flags whose cause ended
// - second critical mode latches only open flag
`timescale 1ns/10ps
`default_nettype none
`include "temp_status_defs.vh"
module temp_result_status_regs (
  input  wire        CLK,
  input  wire        RESETN,
  input  wire        CONV_DONE,
  input  wire        CONV_BUSY,
  input  wire [11:0] REMOTE_RESULT,
  input  wire [6:0]  LIMIT_CAUSES,
  input  wire        SECOND_CRIT_MODE,
  input  wire        RD_STROBE,
  input  wire [7:0]  RD_ADDR,
  output wire [7:0]  RD_DATA,
  output wire [3:0]  REMOTE_LOW_NIBBLE,
  output wire [6:0]  STATUS_FLAGS
);
  // =====================================================================
  // lock states; one-hot so each hold test is a single compare
  localparam [2:0] LOCK_NONE = 3'b001;
  localparam [2:0] LOCK_LOW  = 3'b010;
  localparam [2:0] LOCK_HIGH = 3'b100;

  // =====================================================================
  // declarations
  reg  [2:0] lock_state_r;
  reg  [2:0] lock_state_nxt;
  reg  [7:0] remote_result_upper_bits_r;
  reg  [7:0] remote_result_upper_bits_nxt;
  reg  [3:0] remote_low_r;
  reg  [3:0] remote_low_nxt;
  reg        busy_r;
  reg  [7:0] rd_data_r;
  reg  [7:0] rd_data_nxt;
  reg        rd_high;
  reg        rd_low;
  reg        rd_status;
  reg        rd_unmapped;
  wire       rd_other;
  wire       hold_low;
  wire       hold_high;
  wire       load_high;
  wire       load_low;
  wire [6:0] flags;

  // =====================================================================
  // read decode; one select at most per strobe
  always @* begin
    rd_high     = 1'b0;
    rd_low      = 1'b0;
    rd_status   = 1'b0;
    rd_unmapped = 1'b0;
    if (RD_STROBE) begin
      case (RD_ADDR)
        `ADDR_REMOTE_HIGH: begin
          rd_high = 1'b1;
        end
        `ADDR_REMOTE_LOW: begin
          rd_low = 1'b1;
        end
        `ADDR_ALARM_STATUS: begin
          rd_status = 1'b1;
        end
        default: begin
          rd_unmapped = 1'b1;
        end
      endcase
    end
  end

  // any read but the two result bytes ends the coherence window
  assign rd_other = rd_status || rd_unmapped;

  // =====================================================================
  // byte-coherence lock
  always @* begin
    lock_state_nxt = lock_state_r;
    case (lock_state_r)
      LOCK_NONE: begin
        if (rd_high)
          lock_state_nxt = LOCK_LOW;
        else if (rd_low)
          lock_state_nxt = LOCK_HIGH;
      end
      LOCK_LOW: begin
        if (rd_low || rd_other)
          lock_state_nxt = LOCK_NONE;
      end
      LOCK_HIGH: begin
        if (rd_high || rd_other)
          lock_state_nxt = LOCK_NONE;
      end
      default: begin
        lock_state_nxt = LOCK_NONE;
      end
    endcase
  end

  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      lock_state_r <= LOCK_NONE;
    end else begin
      lock_state_r <= lock_state_nxt;
    end
  end

  // the first read of a pair also guards its own cycle, so a conversion
  // landing on the same edge cannot split the pair
  assign hold_low  = (lock_state_r == LOCK_LOW) ||
                     ((lock_state_r == LOCK_NONE) && rd_high);
  assign hold_high = (lock_state_r == LOCK_HIGH) ||
                     ((lock_state_r == LOCK_NONE) && rd_low);
  assign load_high = CONV_DONE && !hold_high;
  assign load_low  = CONV_DONE && !hold_low;

  // =====================================================================
  // result bytes; no write path exists, so host writes cannot disturb them
  always @* begin
    remote_result_upper_bits_nxt = remote_result_upper_bits_r;
    if (load_high)
      remote_result_upper_bits_nxt = REMOTE_RESULT[`RESULT_HI_MSB:`RESULT_HI_LSB];
  end

  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      remote_result_upper_bits_r <= `RESET_REMOTE_HIGH;
    end else begin
      remote_result_upper_bits_r <= remote_result_upper_bits_nxt;
    end
  end

  always @* begin
    remote_low_nxt = remote_low_r;
    if (load_low)
      remote_low_nxt = REMOTE_RESULT[`RESULT_LO_MSB:`RESULT_LO_LSB];
  end

  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      remote_low_r <= `RESET_REMOTE_LOW;
    end else begin
      remote_low_r <= remote_low_nxt;
    end
  end

  // =====================================================================
  // busy indicator; registered, so it trails the converter by one cycle
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      busy_r <= `RESET_BUSY;
    end else begin
      busy_r <= CONV_BUSY;
    end
  end

  // =====================================================================
  // status flags; causes arrive in bit order 6..0, sampled at conversion end, but in second critical mode all flags except bit 2 follow their cause
  genvar g;
  generate
    for (g = 0; g < `FLAG_COUNT; g = g + 1) begin : gen_flag
      sticky_flag u_flag (
        .clk       (CLK),
        .rst_n     (RESETN),
        .set_evt   (CONV_DONE && LIMIT_CAUSES[g]),
        .cause_now (LIMIT_CAUSES[g]),
        .latch_en  (!SECOND_CRIT_MODE || (g == `BIT_OPEN_JUNCTION)),
        .clr_rd    (rd_status),
        .flag      (flags[g])
      );
    end
  endgenerate

  // =====================================================================
  // read data, registered one cycle after the strobe
  always @* begin
    rd_data_nxt = rd_data_r;
    if (rd_high)
      rd_data_nxt = remote_result_upper_bits_r;
    else if (rd_status)
      rd_data_nxt = {busy_r, flags};
    else if (rd_low)
      rd_data_nxt = {remote_low_r, `LOW_BYTE_PAD};
    else if (rd_unmapped)
      rd_data_nxt = `RESET_RD_DATA;
  end

  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rd_data_r <= `RESET_RD_DATA;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // =====================================================================
  // outputs, each straight from a flip-flop
  assign RD_DATA           = rd_data_r;
  assign REMOTE_LOW_NIBBLE = remote_low_r;
  assign STATUS_FLAGS      = flags;
endmodule // temp_result_status_regs
`default_nettype wire

// ---- sim/temp_regs_monitor.sv ----
// checker of result lock and status flags
// sees the top ports only
`timescale 1ns/10ps
`default_nettype none
module temp_regs_monitor (
  input wire        CLK,
  input wire        RESETN,
  input wire        CONV_DONE,
  input wire        CONV_BUSY,
  input wire        SECOND_CRIT_MODE,
  input wire        RD_STROBE,
  input wire [11:0] REMOTE_RESULT,
  input wire [7:0]  RD_ADDR,
  input wire [7:0]  RD_DATA,
  input wire [6:0]  LIMIT_CAUSES,
  input wire [6:0]  STATUS_FLAGS,
  input wire [3:0]  REMOTE_LOW_NIBBLE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  wire st = RD_STROBE && RD_ADDR == 8'h02;
  reg rel_r;
  reg [3:0] nib_r;
  reg lo_m = 1'b0, hi_m = 1'b0;
  // lock model from the reads alone: high first holds low, low first holds high
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      lo_m <= 1'b0;
      hi_m <= 1'b0;
    end else if (RD_STROBE) begin
      lo_m <= RD_ADDR == 8'h01 && !hi_m;
      hi_m <= RD_ADDR == 8'h10 && !lo_m;
    end
  end
  always @(posedge CLK) begin
    rel_r <= RD_STROBE && RD_ADDR == 8'h03;
    nib_r <= REMOTE_RESULT[3:0];
  end
  chk_low_lock: assert property ((lo_m || (RD_STROBE && RD_ADDR == 8'h01 && !hi_m))
    |=> $stable(REMOTE_LOW_NIBBLE)) else $error("nibble moved");
  chk_lock_release: assert property (rel_r && CONV_DONE && !RD_STROBE
    |=> REMOTE_LOW_NIBBLE == nib_r) else $error("nibble stuck");
  chk_busy_bit: assert property (st && $stable(CONV_BUSY)
    |=> RD_DATA[7] == $past(CONV_BUSY)) else $error("busy bit");
  chk_status_data: assert property (st
    |=> RD_DATA[6:0] == $past(STATUS_FLAGS)) else $error("status data");
  chk_flag_clear: assert property (st && !CONV_DONE && !SECOND_CRIT_MODE
    && LIMIT_CAUSES == 7'h00 |=> STATUS_FLAGS == 7'h00) else $error("no clear");
  chk_open_hold: assert property (st && LIMIT_CAUSES[2] && STATUS_FLAGS[2]
    |=> STATUS_FLAGS[2]) else $error("open flag lost");
  chk_flag_set: assert property (CONV_DONE && !SECOND_CRIT_MODE
    |=> (STATUS_FLAGS & $past(LIMIT_CAUSES)) == $past(LIMIT_CAUSES)) else $error("no set");
  chk_crit_follow: assert property (SECOND_CRIT_MODE ##1 SECOND_CRIT_MODE
    |-> ((STATUS_FLAGS ^ $past(LIMIT_CAUSES)) & 7'h7B) == 7'h00) else $error("follow");
  cover property (st && STATUS_FLAGS != 7'h00);
  cover property (rel_r && CONV_DONE);
  cover property (SECOND_CRIT_MODE && LIMIT_CAUSES != 7'h00);
endmodule // temp_regs_monitor
`default_nettype wire

// ---- sim/smbus_host_model.sv ----
// host model: one register read per call
// assumes calls start on a falling edge
`timescale 1ns/10ps
`default_nettype none
module smbus_host_model (
  input  wire        CLK,
  input  wire  [7:0] RD_DATA,
  output logic       RD_STROBE = 1'b0,
  output logic [7:0] RD_ADDR = 8'h00
);
  // strobe and address for one cycle, data taken at the next falling edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge CLK);
    RD_STROBE = 1'b1;
    RD_ADDR = a;
    @(negedge CLK);
    RD_STROBE = 1'b0;
    RD_ADDR = ~a;
    d = RD_DATA;
  endtask
endmodule // smbus_host_model
`default_nettype wire

// ---- sim/tb_temp_result_status_regs.sv ----
// bench for result lock and status flags
// assumes one host model and CLK at 25 MHz
`timescale 1ns/10ps
`default_nettype none
module tb_temp_result_status_regs;
  logic CLK = 0, RESETN = 0, CONV_DONE = 0, CONV_BUSY = 0, SECOND_CRIT_MODE = 0;
  logic [11:0] REMOTE_RESULT = 12'h000;
  logic [6:0] LIMIT_CAUSES = 7'h00;
  wire RD_STROBE;
  wire [7:0] RD_ADDR, RD_DATA;
  wire [3:0] REMOTE_LOW_NIBBLE;
  wire [6:0] STATUS_FLAGS;
  int fail_count = 0, checks_done = 0;
  always #20 CLK = ~CLK;
  temp_result_status_regs temp_result_status_regs_inst (.*);
  smbus_host_model smbus_host_model_inst (.*);
  task automatic chk(input string n, input logic [7:0] s, e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] a, e);
    logic [7:0] d;
    smbus_host_model_inst.rd(a, d);
    chk("rd_data", d, e);
  endtask
  task automatic conv(input logic [11:0] r, input logic [6:0] c);
    REMOTE_RESULT = r;
    LIMIT_CAUSES = c;
    CONV_DONE = 1;
    @(negedge CLK);
    CONV_DONE = 0;
  endtask
  task automatic test_done;
    if (fail_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge CLK);
    RESETN = 1;
    chk("flags", {1'b0, STATUS_FLAGS}, 8'h00);
    conv(12'hAB5, 7'h00);
    rd(8'h01, 8'hAB);
    conv(12'h123, 7'h00);
    chk("nibble", {4'h0, REMOTE_LOW_NIBBLE}, 8'h05);
    rd(8'h10, 8'h50);
    conv(12'h456, 7'h00);
    rd(8'h10, 8'h60);
    conv(12'h789, 7'h00);
    rd(8'h01, 8'h45);
    rd(8'h03, 8'h00);
    conv(12'hCDE, 7'h00);
    rd(8'h01, 8'hCD);
    chk("nibble", {4'h0, REMOTE_LOW_NIBBLE}, 8'h0E);
    rd(8'h03, 8'h00);
    conv(12'hF1A, 7'h00);
    chk("nibble", {4'h0, REMOTE_LOW_NIBBLE}, 8'h0A);
    rd(8'h01, 8'hF1);
    // sticky flags: a read only clears what has gone away
    conv(12'h000, 7'h7F);
    rd(8'h02, 8'h7F);
    LIMIT_CAUSES = 7'h04;
    rd(8'h02, 8'h7F);
    chk("flags", {1'b0, STATUS_FLAGS}, 8'h04);
    LIMIT_CAUSES = 7'h00;
    rd(8'h02, 8'h04);
    CONV_BUSY = 1;
    rd(8'h02, 8'h80);
    CONV_BUSY = 0;
    SECOND_CRIT_MODE = 1;
    LIMIT_CAUSES = 7'h03;
    repeat (3) @(negedge CLK);
    chk("flags", {1'b0, STATUS_FLAGS}, 8'h03);
    conv(12'h000, 7'h04);
    LIMIT_CAUSES = 7'h00;
    repeat (2) @(negedge CLK);
    chk("flags", {1'b0, STATUS_FLAGS}, 8'h04);
    rd(8'h02, 8'h04);
    chk("flags", {1'b0, STATUS_FLAGS}, 8'h00);
    test_done();
  end
endmodule // tb_temp_result_status_regs
bind temp_result_status_regs temp_regs_monitor temp_regs_monitor_inst (.*);
`default_nettype wire
